// file: include/hub_consts.vh
// Constants for the hub port power, status and repeater block
`ifndef HUB_CONSTS_VH
`define HUB_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define REG_CTRL        8'h00
`define REG_POWER_SET   8'h04
`define REG_POWER_CLR   8'h08
`define REG_PORT_EN     8'h0C
`define REG_LOW_SPEED   8'h10
`define REG_STATUS      8'h14
`define REG_INT_STAT    8'h18
`define REG_INT_MASK    8'h1C

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_GLOBAL_BIT     0
`define CTRL_UNSWITCHED_BIT 1
`define ST_SELF_BIT         4
`define ST_LOCAL_GOOD_BIT   5
`define ST_REF_OK_BIT       6
`define ST_TEST_OK_BIT      7
`define INT_LOCAL_BIT       4
`define CTRL_RST            2'h0
`define INT_MASK_RST        5'h00
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_SYS_HZ          25000000
`define CLK_SYS_PS          40000
`define OC_BLINK_HALF_MS    500
`define OC_BLINK_HALF_CYC   (`OC_BLINK_HALF_MS * (`CLK_SYS_HZ / 1000))
`define FS_BIT_TIME_PS      83333
`define LS_EN_BIT_TIMES     4
`define LS_EN_MAX_CYC       ((`LS_EN_BIT_TIMES * `FS_BIT_TIME_PS) / `CLK_SYS_PS)
`define REF_OSC_HZ          6000000
`define CORE_HZ             48000000
`define REF_MULT            (`CORE_HZ / `REF_OSC_HZ)
`define REF_PER_MIN_CYC     3
`define REF_PER_MAX_CYC     6

`endif

// file: design/sync_bits.v
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module sync_bits #(
  parameter WIDTH = 1
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // sync_bits

// file: design/ref_clock_check.v
// Reference oscillator buffer and rate check
`timescale 1ns/100ps
`include "hub_consts.vh"
module ref_clock_check #(
  parameter PER_MIN = `REF_PER_MIN_CYC,
  parameter PER_MAX = `REF_PER_MAX_CYC
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire osc_sync,
  output reg  osc_out,
  output reg  ref_ok
);
  reg [3:0] per_cnt_r;
  reg       osc_d_r;
  wire      rise = osc_sync & ~osc_d_r;

  // Inverting amplifier copy and period check of the reference
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_out   <= 1'b0;
      osc_d_r   <= 1'b0;
      per_cnt_r <= 4'h0;
      ref_ok    <= 1'b0;
    end else begin
      osc_out <= ~osc_sync;
      osc_d_r <= osc_sync;
      if (rise) begin
        per_cnt_r <= 4'h1;
        ref_ok    <= (per_cnt_r >= PER_MIN) && (per_cnt_r <= PER_MAX);
      end else if (per_cnt_r != 4'hF) begin
        per_cnt_r <= per_cnt_r + 4'h1;
      end else begin
        ref_ok <= 1'b0;
      end
    end
  end
endmodule // ref_clock_check

// file: design/hub_port_ctrl.v
// Hub port power, overcurrent, indicator, repeater and register logic
`timescale 1ns/100ps
`include "hub_consts.vh"
module hub_port_ctrl #(
  parameter        NPORT     = 4,
  parameter        AW        = 8,
  parameter [31:0] BLINK_CYC = `OC_BLINK_HALF_CYC
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [AW-1:0]    s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [AW-1:0]    s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  output wire             irq,
  input  wire             osc_in,
  output wire             osc_out,
  input  wire             test_in,
  input  wire             self_powered_sel,
  input  wire             local_supply_sense,
  input  wire [NPORT-1:0] overcurrent_sense_n,
  output reg  [NPORT-1:0] port_power_enable,
  output reg  [NPORT-1:0] port_indicator_n,
  input  wire             preamble_seen,
  input  wire             upstream_dp_in,
  input  wire             upstream_dm_in,
  output reg              upstream_dp_out,
  output reg              upstream_dm_out,
  output reg              upstream_oe,
  input  wire [NPORT-1:0] down_dp_in,
  input  wire [NPORT-1:0] down_dm_in,
  output reg  [NPORT-1:0] down_dp_out,
  output reg  [NPORT-1:0] down_dm_out,
  output reg  [NPORT-1:0] down_oe
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam SW = 2 * NPORT + NPORT + 6;
  wire [SW-1:0]    sync_v;
  wire [NPORT-1:0] oc_act;
  wire             self_pw, lps, test_ok, osc_s, up_dp, up_dm;
  wire [NPORT-1:0] dn_dp, dn_dm;
  wire             ref_ok;
  wire             self_good = self_pw & lps;

  sync_bits #(.WIDTH(SW)) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({~overcurrent_sense_n, self_powered_sel, local_supply_sense,
                test_in, osc_in, upstream_dp_in, upstream_dm_in,
                down_dp_in, down_dm_in}),
    .sync_out (sync_v)
  );
  assign {oc_act, self_pw, lps, test_ok, osc_s, up_dp, up_dm,
          dn_dp, dn_dm} = sync_v;

  ref_clock_check u_ref (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .osc_sync (osc_s),
    .osc_out  (osc_out),
    .ref_ok   (ref_ok)
  );

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg [AW-1:0]    awaddr_r, araddr_r;
  reg             aw_have_r, w_have_r;
  reg [31:0]      wdata_r;
  reg [3:0]       wstrb_r;
  reg [1:0]       ctrl_r;
  reg [NPORT-1:0] en_r, ls_r, blink_r, oc_d_r;
  reg [4:0]       int_stat_r, int_mask_r;
  reg             lps_d_r;
  wire            wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire            wr_b0 = wr_go & wstrb_r[0];
  wire            wr_ok = (awaddr_r[1:0] == 2'h0) && (awaddr_r <= `REG_INT_MASK);
  wire            rd_ok = (araddr_r[1:0] == 2'h0) && (araddr_r <= `REG_INT_MASK);
  reg             ar_have_r;

  assign s_axi_awready = ~aw_have_r;
  assign s_axi_wready  = ~w_have_r;
  assign s_axi_arready = ~ar_have_r & ~s_axi_rvalid;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      awaddr_r     <= {AW{1'b0}};
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      ar_have_r    <= 1'b0;
      araddr_r     <= {AW{1'b0}};
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid & ~aw_have_r) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_have_r) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        ar_have_r <= 1'b1;
        araddr_r  <= s_axi_araddr;
      end
      if (ar_have_r) begin
        ar_have_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr_r)
          `REG_CTRL:      s_axi_rdata <= {30'h0000_0000, ctrl_r};
          `REG_POWER_SET: s_axi_rdata <= {28'h000_0000, port_power_enable};
          `REG_POWER_CLR: s_axi_rdata <= {28'h000_0000, port_power_enable};
          `REG_PORT_EN:   s_axi_rdata <= {28'h000_0000, en_r};
          `REG_LOW_SPEED: s_axi_rdata <= {28'h000_0000, ls_r};
          `REG_STATUS:    s_axi_rdata <= {24'h00_0000, test_ok, ref_ok,
                                          self_good, self_pw, oc_act};
          `REG_INT_STAT:  s_axi_rdata <= {27'h000_0000, int_stat_r};
          `REG_INT_MASK:  s_axi_rdata <= {27'h000_0000, int_mask_r};
          default:        s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Power, overcurrent, enable and indicator per port
  // ****************************************************************
  wire             glob   = ctrl_r[`CTRL_GLOBAL_BIT];
  wire             unsw   = ctrl_r[`CTRL_UNSWITCHED_BIT] & self_pw;
  wire [NPORT-1:0] wset   = (wr_b0 && awaddr_r == `REG_POWER_SET) ?
                            wdata_r[NPORT-1:0] : {NPORT{1'b0}};
  wire [NPORT-1:0] wclr   = (wr_b0 && awaddr_r == `REG_POWER_CLR) ?
                            wdata_r[NPORT-1:0] : {NPORT{1'b0}};
  wire [NPORT-1:0] set_c  = glob ? {NPORT{|wset}} : wset;
  wire [NPORT-1:0] clr_c  = glob ? {NPORT{|wclr}} : wclr;
  wire [NPORT-1:0] oc_new = oc_act & ~oc_d_r;
  wire [NPORT-1:0] oc_f   = glob ? {NPORT{|oc_act}} : oc_act;
  wire [NPORT-1:0] oc_e   = glob ? {NPORT{|oc_new}} : oc_new;
  wire             wr_en  = wr_b0 && awaddr_r == `REG_PORT_EN;
  reg  [31:0]      blink_cnt_r;
  reg              blink_ph_r;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_ph_r  <= 1'b0;
      oc_d_r      <= {NPORT{1'b0}};
    end else begin
      oc_d_r <= oc_act;
      if (blink_cnt_r >= BLINK_CYC - 32'h0000_0001) begin
        blink_cnt_r <= 32'h0000_0000;
        blink_ph_r  <= ~blink_ph_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NPORT; i = i + 1) begin : g_port
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          port_power_enable[i] <= 1'b0;
          en_r[i]              <= 1'b0;
          ls_r[i]              <= 1'b0;
          blink_r[i]           <= 1'b0;
          port_indicator_n[i]  <= 1'b1;
        end else begin
          if (oc_f[i] | clr_c[i] | ~test_ok) begin
            port_power_enable[i] <= 1'b0;
          end else if (set_c[i] | unsw) begin
            port_power_enable[i] <= 1'b1;
          end
          if (oc_f[i] | ~port_power_enable[i] | ~test_ok) begin
            en_r[i] <= 1'b0;
          end else if (wr_en) begin
            en_r[i] <= wdata_r[i];
          end
          if (wr_b0 && awaddr_r == `REG_LOW_SPEED) begin
            ls_r[i] <= wdata_r[i];
          end
          if (oc_e[i]) begin
            blink_r[i] <= 1'b1;
          end else if (clr_c[i]) begin
            blink_r[i] <= 1'b0;
          end
          port_indicator_n[i] <= blink_r[i] ? ~blink_ph_r :
                                 ~(en_r[i] & port_power_enable[i]);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Control, interrupt status and mask
  // ****************************************************************
  wire [4:0] int_ev = {self_pw & (lps ^ lps_d_r), oc_e};
  wire [4:0] w1c    = (wr_b0 && awaddr_r == `REG_INT_STAT) ?
                      wdata_r[4:0] : 5'h00;
  assign irq = |(int_stat_r & int_mask_r);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r     <= `CTRL_RST;
      int_mask_r <= `INT_MASK_RST;
      int_stat_r <= 5'h00;
      lps_d_r    <= 1'b0;
    end else begin
      lps_d_r    <= lps;
      int_stat_r <= (int_stat_r & ~w1c) | int_ev;
      if (wr_b0 && awaddr_r == `REG_CTRL) begin
        ctrl_r <= wdata_r[1:0];
      end
      if (wr_b0 && awaddr_r == `REG_INT_MASK) begin
        int_mask_r <= wdata_r[4:0];
      end
    end
  end

  // ****************************************************************
  // Repeater
  // ****************************************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_DOWN = 3'b010;
  localparam ST_UP   = 3'b100;
  reg [2:0]       st_r;
  reg [1:0]       src_r;
  reg             se0_r, lswin_r;
  reg [1:0]       act_src;
  reg             act_any;
  reg [NPORT-1:0] dn_idle;
  integer         k;

  always @* begin
    act_any = 1'b0;
    act_src = 2'h0;
    for (k = NPORT - 1; k >= 0; k = k - 1) begin
      dn_idle[k] = ls_r[k] ? (dn_dm[k] & ~dn_dp[k]) : (dn_dp[k] & ~dn_dm[k]);
      if (en_r[k] & ~dn_idle[k]) begin
        act_any = 1'b1;
        act_src = k[1:0];
      end
    end
  end

  wire up_j    = up_dp & ~up_dm;
  wire up_se0  = ~up_dp & ~up_dm;
  wire src_se0 = ~dn_dp[src_r] & ~dn_dm[src_r];
  wire src_idl = dn_idle[src_r];
  wire [NPORT-1:0] fwd = en_r & (~ls_r | {NPORT{lswin_r}});

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r            <= ST_IDLE;
      src_r           <= 2'h0;
      se0_r           <= 1'b0;
      lswin_r         <= 1'b0;
      upstream_dp_out <= 1'b1;
      upstream_dm_out <= 1'b0;
      upstream_oe     <= 1'b0;
      down_dp_out     <= {NPORT{1'b0}};
      down_dm_out     <= {NPORT{1'b0}};
      down_oe         <= {NPORT{1'b0}};
    end else begin
      case (st_r)
        ST_IDLE: begin
          se0_r   <= 1'b0;
          lswin_r <= 1'b0;
          down_oe <= {NPORT{1'b0}};
          upstream_oe <= 1'b0;
          if (~up_j & test_ok) begin
            st_r <= ST_DOWN;
          end else if (act_any & test_ok) begin
            st_r  <= ST_UP;
            src_r <= act_src;
          end
        end
        ST_DOWN: begin
          if (preamble_seen) begin
            lswin_r <= 1'b1;
          end
          down_dp_out <= {NPORT{up_dp}};
          down_dm_out <= {NPORT{up_dm}};
          down_oe     <= fwd & {NPORT{test_ok}};
          if (up_se0) begin
            se0_r <= 1'b1;
          end else if (se0_r & up_j) begin
            st_r <= ST_IDLE;
          end
        end
        ST_UP: begin
          upstream_dp_out <= dn_dp[src_r];
          upstream_dm_out <= dn_dm[src_r];
          upstream_oe     <= 1'b1;
          if (~en_r[src_r]) begin
            st_r <= ST_IDLE;
          end else if (src_se0) begin
            se0_r <= 1'b1;
          end else if (se0_r & src_idl) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule // hub_port_ctrl

// file: bench/hub_port_ctrl_asserts.sv
// Checker bound to the hub port control block
`timescale 1ns/100ps
module hub_port_ctrl_asserts #(
  parameter NPORT = 4
) (
  input wire             clk_sys,
  input wire             rst_n,
  input wire             s_axi_awvalid,
  input wire             s_axi_awready,
  input wire             s_axi_wvalid,
  input wire             s_axi_wready,
  input wire [1:0]       s_axi_bresp,
  input wire             s_axi_bvalid,
  input wire             s_axi_bready,
  input wire             s_axi_arvalid,
  input wire             s_axi_arready,
  input wire [31:0]      s_axi_rdata,
  input wire             s_axi_rvalid,
  input wire             s_axi_rready,
  input wire             test_in,
  input wire [NPORT-1:0] overcurrent_sense_n,
  input wire [NPORT-1:0] port_power_enable,
  input wire [NPORT-1:0] port_indicator_n,
  input wire             upstream_oe,
  input wire [NPORT-1:0] down_oe
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence test_low;
    !test_in [*3];
  endsequence
  chk_write_answer:
    assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer:
    assert property (rd_take |-> ##[1:3] s_axi_rvalid)
    else $error("read response late");
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_test_off:
    assert property (test_low |=> port_power_enable == '0 && down_oe == '0)
    else $error("ports active with test input low");
  chk_reset_idle:
    assert property (!$past(rst_n) |-> port_power_enable == '0
      && &port_indicator_n && !s_axi_bvalid && !s_axi_rvalid
      && down_oe == '0 && !upstream_oe)
    else $error("outputs not idle after reset");
  for (genvar g = 0; g < NPORT; g++) begin : oc
    chk_oc_power_cut:
      assert property (!overcurrent_sense_n[g] [*3] |=> !port_power_enable[g])
      else $error("power kept during overcurrent");
  end
endmodule // hub_port_ctrl_asserts

bind hub_port_ctrl hub_port_ctrl_asserts #(.NPORT(NPORT))
  hub_port_ctrl_asserts_i (.*);

// file: bench/usb_line_model.sv
// Behavioural party driving one USB line pair
`timescale 1ns/100ps
module usb_line_model (
  input  wire       clk_sys,
  input  wire       go,
  input  wire [7:0] sym,
  output reg        dp = 1'b1,
  output reg        dm = 1'b0
);
  reg [3:0] cnt_r = 4'h0;
  reg [7:0] sh_r  = 8'h00;
  // Eight data symbols, two SE0, then released to idle J
  always @(posedge clk_sys) begin
    if (go) begin
      cnt_r <= 4'hb;
      sh_r  <= sym;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      sh_r  <= {sh_r[6:0], 1'b1};
    end
    dp <= (cnt_r > 4'h3) ? sh_r[7] : !(cnt_r == 4'h3 || cnt_r == 4'h2);
    dm <= (cnt_r > 4'h3) ? !sh_r[7] : 1'b0;
  end
endmodule // usb_line_model

// file: bench/tb.sv
// Self-checking bench for the hub port control block
`timescale 1ns/100ps
`include "hub_consts.vh"
module tb;
  reg        clk_sys = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0;
  reg        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  reg        s_axi_rready = 1'b0, osc_in = 1'b0, test_in = 1'b1;
  reg        self_powered_sel = 1'b1, local_supply_sense = 1'b1;
  reg        preamble_seen = 1'b0, host_go = 1'b0, dev_go = 1'b0, p;
  reg [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sym = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0000_0000, lfsr_r = 32'h0000_778e, v;
  reg [3:0]  s_axi_wstrb = 4'hf, overcurrent_sense_n = 4'hf;
  reg [1:0]  osc_cnt = 2'h0;
  wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire       s_axi_rvalid, irq, osc_out, upstream_dp_in, upstream_dm_in;
  wire       upstream_dp_out, upstream_dm_out, upstream_oe, dev_dp, dev_dm;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] port_power_enable, port_indicator_n, down_dp_out;
  wire [3:0] down_dm_out, down_oe, down_dp_in, down_dm_in;
  int        failures = 0, checks_done = 0, seen [0:4], base [0:4], t;
  reg [33:0] exp_q [$];

  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always #20 clk_sys = ~clk_sys;
  assign down_dp_in = {lfsr_r[1:0], 1'b0, dev_dp};
  assign down_dm_in = {lfsr_r[3:2], 1'b1, dev_dm};
  hub_port_ctrl #(.BLINK_CYC(32'h0000_0004)) hub_port_ctrl_i (.*);
  usb_line_model host_i (.clk_sys(clk_sys), .go(host_go), .sym(sym),
    .dp(upstream_dp_in), .dm(upstream_dm_in));
  usb_line_model dev_i (.clk_sys(clk_sys), .go(dev_go), .sym(sym),
    .dp(dev_dp), .dm(dev_dm));

  task automatic cmp(input string n, input [33:0] e, input [33:0] g);
    checks_done++;
    if (e !== g) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r = 2'h0);
    exp_q.push_back({r, 32'h0000_0000});
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] e, input [1:0] r = 2'h0);
    exp_q.push_back({r, e});
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // Preamble pulse lands while the repeater forwards the host packet
  task automatic burst(input d, input pre, input [7:0] s);
    @(posedge clk_sys);
    base = seen;
    host_go <= !d;
    dev_go <= d;
    sym <= s;
    @(posedge clk_sys);
    host_go <= 1'b0;
    dev_go <= 1'b0;
    tick(5);
    preamble_seen <= pre;
    @(posedge clk_sys);
    preamble_seen <= 1'b0;
    tick(14);
    for (int k = 0; k < 5; k++)
      base[k] = seen[k] - base[k];
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Monitor, oscillator and random line noise
  // ****************************************************************
  always @(posedge clk_sys) begin
    lfsr_r <= lfsr(lfsr_r);
    osc_cnt <= osc_cnt + 2'h1;
    osc_in <= osc_cnt[1];
    for (int k = 0; k < 4; k++)
      if (down_oe[k]) seen[k] <= seen[k] + 1;
    if (upstream_oe) seen[4] <= seen[4] + 1;
    if (s_axi_bvalid && s_axi_bready)
      cmp("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0000_0000});
    if (s_axi_rvalid && s_axi_rready)
      cmp("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    final_report;
  end
  initial begin
    tick(20);
    rst_n <= 1'b1;
    tick(20);
    wr(`REG_INT_STAT, 32'h0000_001f);
    rd(`REG_CTRL, 32'h0000_0000);
    rd(`REG_INT_MASK, 32'h0000_0000);
    rd(`REG_POWER_SET, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000, `RESP_SLVERR);
    wr(8'h02, 32'h0000_000f, `RESP_SLVERR);
    v = lfsr_r;
    wr(`REG_INT_MASK, v);
    rd(`REG_INT_MASK, {27'h000_0000, v[4:0]});
    for (int m = 0; m < 4; m++) begin
      self_powered_sel <= m[1];
      local_supply_sense <= m[0];
      tick(5);
      rd(`REG_STATUS, {24'h00_0000, 2'b11, m[1] & m[0], m[1], 4'h0});
    end
    wr(`REG_INT_STAT, 32'h0000_001f);
    local_supply_sense <= 1'b0;
    tick(5);
    rd(`REG_INT_STAT, 32'h0000_0010);
    self_powered_sel <= 1'b0;
    tick(5);
    wr(`REG_INT_STAT, 32'h0000_001f);
    local_supply_sense <= 1'b1;
    tick(5);
    rd(`REG_INT_STAT, 32'h0000_0000);
    self_powered_sel <= 1'b1;
    tick(5);
    wr(`REG_INT_STAT, 32'h0000_001f);
    for (int i = 0; i < 4; i++) begin
      wr(`REG_POWER_SET, 32'h0000_0001 << i);
      rd(`REG_POWER_CLR, (32'h0000_0002 << i) - 32'h0000_0001);
    end
    wr(`REG_LOW_SPEED, 32'h0000_0002);
    wr(`REG_PORT_EN, 32'h0000_000f);
    tick(2);
    cmp("indicator", 4'h0, port_indicator_n);
    wr(`REG_POWER_CLR, 32'h0000_0008);
    tick(2);
    cmp("indicator", 4'h8, port_indicator_n);
    rd(`REG_PORT_EN, 32'h0000_0007);
    wr(`REG_PORT_EN, 32'h0000_0003);
    burst(1'b0, 1'b0, 8'h5a);
    cmp("full_speed_out", 1'b1, base[0] != 0);
    cmp("low_speed_quiet", 1'b0, base[1] != 0);
    burst(1'b0, 1'b1, 8'h96);
    cmp("low_speed_out", 1'b1, base[1] != 0);
    burst(1'b1, 1'b0, 8'h3c);
    cmp("upstream_out", 1'b1, base[4] != 0);
    wr(`REG_POWER_SET, 32'h0000_000f);
    wr(`REG_PORT_EN, 32'h0000_000f);
    wr(`REG_INT_MASK, 32'h0000_000f);
    overcurrent_sense_n <= 4'hb;
    tick(4);
    cmp("power", 4'hb, port_power_enable);
    cmp("irq", 1'b1, irq);
    rd(`REG_STATUS, 32'h0000_00f4);
    rd(`REG_INT_STAT, 32'h0000_0004);
    wr(`REG_POWER_SET, 32'h0000_0004);
    rd(`REG_POWER_SET, 32'h0000_000b);
    t = 0;
    p = port_indicator_n[2];
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      t += (port_indicator_n[2] !== p);
      p = port_indicator_n[2];
    end
    cmp("blink", 1'b1, t >= 3);
    overcurrent_sense_n <= 4'hf;
    tick(4);
    wr(`REG_INT_STAT, 32'h0000_001f);
    tick(1);
    cmp("irq", 1'b0, irq);
    wr(`REG_POWER_CLR, 32'h0000_0004);
    tick(10);
    cmp("blink_stop", 1'b1, port_indicator_n[2]);
    wr(`REG_CTRL, 32'h0000_0001);
    wr(`REG_POWER_CLR, 32'h0000_0001);
    rd(`REG_POWER_SET, 32'h0000_0000);
    wr(`REG_POWER_SET, 32'h0000_0002);
    rd(`REG_POWER_SET, 32'h0000_000f);
    test_in <= 1'b0;
    tick(4);
    cmp("power", 4'h0, port_power_enable);
    rd(`REG_STATUS, 32'h0000_0070);
    final_report;
  end
endmodule // tb
